// ==== hdl/rsc_pkg.sv ====
// Purpose: Shared constants for the reset strap capture block
// Assumes: APB3 slave, 32-bit data, byte addresses
// Notes:   Strap field positions, register map, settle count
`default_nettype none
package rsc_pkg;

  // ----------------------------------------------------------------
  // Pin widths
  // ----------------------------------------------------------------
  localparam int STRAP_W = 16;
  localparam int USER_W  = 8;
  localparam int ADDR_W  = 12;
  localparam int DATA_W  = 32;

  // ----------------------------------------------------------------
  // Strap field positions
  // ----------------------------------------------------------------
  localparam int SB_DEBOUNCE  = 0;
  localparam int SB_RSVD_LO   = 1;
  localparam int SB_RSVD_HI   = 2;
  localparam int SB_UNMANAGED = 3;
  localparam int SB_ID_LSB    = 4;
  localparam int SB_ID_MSB    = 6;
  localparam int SB_NO_EEPROM = 7;
  localparam int SB_MFG8      = 8;
  localparam int SB_MODDET    = 9;
  localparam int SB_MFG10     = 10;
  localparam int SB_PWRSAVE   = 11;
  localparam int SB_TMO_RST   = 12;
  localparam int SB_MFG_LSB   = 13;
  localparam int SB_MFG_MSB   = 15;

  // Fixed strap values the board must provide
  localparam logic [STRAP_W-1:0] STRAP_FIXED_MASK  = 16'he506;
  localparam logic [STRAP_W-1:0] STRAP_FIXED_VALUE = 16'he106;

  // ----------------------------------------------------------------
  // Status pin positions after initialization
  // ----------------------------------------------------------------
  localparam int ST_INIT_STARTED = 0;
  localparam int ST_SELFTEST     = 1;
  localparam int ST_INIT_DONE    = 2;
  localparam int ST_CHECKSUM_OK  = 3;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_STRAP_CAPTURE  = 12'h000;
  localparam logic [ADDR_W-1:0] REG_USER_READBACK  = 12'h004;
  localparam logic [ADDR_W-1:0] REG_CONFIG_STATUS  = 12'h008;
  localparam logic [ADDR_W-1:0] REG_INIT_STATUS    = 12'h00c;

  // Config status layout
  localparam int CS_VALID     = 0;
  localparam int CS_FAULT     = 1;
  localparam int CS_DEBOUNCE  = 2;
  localparam int CS_UNMANAGED = 3;
  localparam int CS_EEPROM    = 4;
  localparam int CS_MODDET    = 5;
  localparam int CS_PWRSAVE   = 6;
  localparam int CS_TMO_RST   = 7;
  localparam int CS_ID_LSB    = 8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          SETTLE_CYCLES = 4;
  localparam logic [2:0]  SETTLE_LAST   = 3'h3;

  typedef enum logic [1:0] {
    RSC_SETTLE = 2'b00,
    RSC_RUN    = 2'b01
  } rsc_phase_t;

endpackage
`default_nettype wire

// ==== hdl/rsc_top.sv ====
// Purpose: Capture configuration straps at reset, decode them, then drive status pins
// Assumes: Pins settle under external pulls while RESET is high; APB3 master
// Notes:   Straps are latched a few cycles after release, once synchronised
//
// Operation
// - Sample strap test pins and port transmit enables only around reset.
// - Pulled-up pin reads as one, pulled-down pin reads as zero.
// - Strap bit 0 high enables strobe debounce, low disables it.
// - Strap bit 3 low selects lightly managed serial mode with host frames.
// - Strap bit 3 high selects unmanaged mode, blocks host frames, allows EEPROM boot.
// - Strap bits 6 to 4 form the default serial management address.
// - Serial identifier has bit 4 as LSB and bit 6 as MSB.
// - Strap bit 7 high means EEPROM absent, low means installed.
// - Strap bit 9 high enables module detection for hot swap.
// - Strap bit 11 high enables MAC power saving mode.
// - Strap bit 12 high enables timeout-triggered internal reset.
// - Port transmit enables captured as user straps, readable by software.
// - After reset strap pins show init started, self-test, done, checksum good.
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module rsc_top
  import rsc_pkg::*;
(
  input  wire logic               CLK_SYS,
  input  wire logic               RESET,
  // Strap test pins, bidirectional
  input  wire logic [STRAP_W-1:0] STRAP_TEST_PINS_IN,
  output logic      [STRAP_W-1:0] STRAP_TEST_PINS_OUT,
  output logic      [STRAP_W-1:0] STRAP_TEST_PINS_OE,
  // Port transmit enables, sampled as user straps
  input  wire logic [USER_W-1:0]  PORT_TX_ENABLE_PINS_IN,
  // Decoded configuration
  output logic                    CONFIG_VALID,
  output logic                    STRAP_FAULT,
  output logic                    STROBE_DEBOUNCE_EN,
  output logic                    LIGHTLY_MANAGED,
  output logic                    HOST_FRAME_BLOCK,
  output logic                    EEPROM_PRESENT,
  output logic                    EEPROM_BOOT_EN,
  output logic      [2:0]         SERIAL_DEVICE_ID,
  output logic                    MODULE_DETECT_EN,
  output logic                    MAC_POWER_SAVE_EN,
  output logic                    TIMEOUT_RESET_EN,
  output logic      [USER_W-1:0]  USER_STRAP_READBACK,
  // APB slave
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [ADDR_W-1:0]  PADDR,
  input  wire logic [DATA_W-1:0]  PWDATA,
  output logic      [DATA_W-1:0]  PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [STRAP_W-1:0] strap_s1;
  logic [STRAP_W-1:0] strap_s2;
  logic [STRAP_W-1:0] strap_s3;
  logic [STRAP_W-1:0] strap_filt;
  logic [USER_W-1:0]  user_s1;
  logic [USER_W-1:0]  user_s2;
  logic [USER_W-1:0]  user_s3;
  logic [USER_W-1:0]  user_filt;

  rsc_phase_t         phase;
  logic [2:0]         settle_cnt;
  logic               latch_now;

  logic [STRAP_W-1:0] strap_cap;
  logic [USER_W-1:0]  user_cap;
  logic               cap_valid;

  logic               sw_selftest;
  logic               sw_init_done;
  logic               sw_checksum_ok;
  logic               init_started;

  logic               apb_setup;
  logic               apb_write;
  logic               addr_ok;
  logic [DATA_W-1:0]  next_prdata;
  logic [DATA_W-1:0]  cfg_word;
  logic [DATA_W-1:0]  init_word;

  // Strap decode results, kept only on latch_now; status pin pattern, driven each cycle in RSC_RUN
  logic               next_fault;
  logic               next_debounce;
  logic               next_unmanaged;
  logic               next_eeprom_present;
  logic               next_eeprom_boot;
  logic [2:0]         next_dev_id;
  logic               next_moddet;
  logic               next_pwrsave;
  logic               next_tmo_rst;
  logic [STRAP_W-1:0] next_status_pins;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [2:0] dev_id(input logic [STRAP_W-1:0] s);
    dev_id = s[SB_ID_MSB:SB_ID_LSB];
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == REG_STRAP_CAPTURE) || (a == REG_USER_READBACK) ||
                (a == REG_CONFIG_STATUS) || (a == REG_INIT_STATUS);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // No reset here: chain must keep tracking pins while RESET is high
  always_ff @(posedge CLK_SYS) begin
    strap_s1 <= STRAP_TEST_PINS_IN;
    strap_s2 <= strap_s1;
    strap_s3 <= strap_s2;
    user_s1  <= PORT_TX_ENABLE_PINS_IN;
    user_s2  <= user_s1;
    user_s3  <= user_s2;
  end

  // A bit only changes once stages two and three agree
  always_ff @(posedge CLK_SYS) begin
    for (int i = 0; i < STRAP_W; i++) begin
      if (strap_s2[i] == strap_s3[i]) begin
        strap_filt[i] <= strap_s3[i];
      end
    end
    for (int j = 0; j < USER_W; j++) begin
      if (user_s2[j] == user_s3[j]) begin
        user_filt[j] <= user_s3[j];
      end
    end
  end

  // ----------------------------------------------------------------
  // Capture sequencing
  // ----------------------------------------------------------------
  // Pins stay undriven through reset and the settle window
  // Settle covers the three-flop chain and the agreement stage
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      phase      <= RSC_SETTLE;
      settle_cnt <= 3'h0;
    end else begin
      unique case (phase)
        RSC_SETTLE: begin
          if (settle_cnt == SETTLE_LAST) begin
            phase <= RSC_RUN;
          end else begin
            settle_cnt <= settle_cnt + 3'h1;
          end
        end
        RSC_RUN: begin
          phase <= RSC_RUN;
        end
      endcase
    end
  end

  assign latch_now = (phase == RSC_SETTLE) && (settle_cnt == SETTLE_LAST);

  // Latched once per reset; later pin activity cannot disturb it
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      strap_cap <= '0;
      user_cap  <= '0;
      cap_valid <= 1'b0;
    end else if (latch_now) begin
      strap_cap <= strap_filt;
      user_cap  <= user_filt;
      cap_valid <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Strap decode
  // ----------------------------------------------------------------
  // Decoded from the filtered pins every cycle
  always_comb begin
    next_fault          = (strap_filt & STRAP_FIXED_MASK) != STRAP_FIXED_VALUE;
    next_debounce       = strap_filt[SB_DEBOUNCE];
    next_unmanaged      = strap_filt[SB_UNMANAGED];
    next_eeprom_present = !strap_filt[SB_NO_EEPROM];
    // Boot load only makes sense without a host on the serial bus
    next_eeprom_boot    = next_unmanaged && next_eeprom_present;
    next_dev_id         = dev_id(strap_filt);
    next_moddet         = strap_filt[SB_MODDET];
    next_pwrsave        = strap_filt[SB_PWRSAVE];
    next_tmo_rst        = strap_filt[SB_TMO_RST];
  end

  // ----------------------------------------------------------------
  // Decoded configuration
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      CONFIG_VALID       <= 1'b0;
      STRAP_FAULT        <= 1'b0;
      STROBE_DEBOUNCE_EN <= 1'b0;
      LIGHTLY_MANAGED    <= 1'b0;
      HOST_FRAME_BLOCK   <= 1'b0;
      EEPROM_PRESENT     <= 1'b0;
      EEPROM_BOOT_EN     <= 1'b0;
      SERIAL_DEVICE_ID   <= 3'h0;
      MODULE_DETECT_EN   <= 1'b0;
      MAC_POWER_SAVE_EN  <= 1'b0;
      TIMEOUT_RESET_EN   <= 1'b0;
      USER_STRAP_READBACK <= '0;
    end else if (latch_now) begin
      CONFIG_VALID       <= 1'b1;
      // Flags a board that breaks the reserved and manufacturing straps
      STRAP_FAULT        <= next_fault;
      STROBE_DEBOUNCE_EN <= next_debounce;
      LIGHTLY_MANAGED    <= !next_unmanaged;
      HOST_FRAME_BLOCK   <= next_unmanaged;
      EEPROM_PRESENT     <= next_eeprom_present;
      EEPROM_BOOT_EN     <= next_eeprom_boot;
      SERIAL_DEVICE_ID   <= next_dev_id;
      MODULE_DETECT_EN   <= next_moddet;
      MAC_POWER_SAVE_EN  <= next_pwrsave;
      TIMEOUT_RESET_EN   <= next_tmo_rst;
      USER_STRAP_READBACK <= user_filt;
    end
  end

  // ----------------------------------------------------------------
  // Initialization status
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      init_started <= 1'b0;
    end else if (latch_now) begin
      init_started <= 1'b1;
    end
  end

  // Self-test, done and checksum are reported by the init engine via software
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      sw_selftest    <= 1'b0;
      sw_init_done   <= 1'b0;
      sw_checksum_ok <= 1'b0;
    end else if (apb_write && (PADDR == REG_INIT_STATUS)) begin
      sw_selftest    <= PWDATA[ST_SELFTEST];
      sw_init_done   <= PWDATA[ST_INIT_DONE];
      sw_checksum_ok <= PWDATA[ST_CHECKSUM_OK];
    end
  end

  // ----------------------------------------------------------------
  // Strap pins as status outputs
  // ----------------------------------------------------------------
  // Reserved status pins 15 to 4 stay low
  always_comb begin
    next_status_pins                  = '0;
    next_status_pins[ST_INIT_STARTED] = init_started;
    next_status_pins[ST_SELFTEST]     = sw_selftest;
    next_status_pins[ST_INIT_DONE]    = sw_init_done;
    next_status_pins[ST_CHECKSUM_OK]  = sw_checksum_ok;
  end

  // Drive only after capture so the pull resistors are never fought
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      STRAP_TEST_PINS_OUT <= '0;
      STRAP_TEST_PINS_OE  <= '0;
    end else if (phase == RSC_RUN) begin
      STRAP_TEST_PINS_OE  <= '1;
      STRAP_TEST_PINS_OUT <= next_status_pins;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Zero wait states: read data is prepared during the setup phase
  assign apb_setup = PSEL && !PENABLE;
  assign apb_write = PSEL && PENABLE && PWRITE && addr_ok;
  assign PREADY    = 1'b1;

  // Read-only words ignore writes and raise no error
  always_comb begin
    cfg_word = '0;
    cfg_word[CS_VALID]     = cap_valid;
    cfg_word[CS_FAULT]     = STRAP_FAULT;
    cfg_word[CS_DEBOUNCE]  = STROBE_DEBOUNCE_EN;
    cfg_word[CS_UNMANAGED] = HOST_FRAME_BLOCK;
    cfg_word[CS_EEPROM]    = EEPROM_PRESENT;
    cfg_word[CS_MODDET]    = MODULE_DETECT_EN;
    cfg_word[CS_PWRSAVE]   = MAC_POWER_SAVE_EN;
    cfg_word[CS_TMO_RST]   = TIMEOUT_RESET_EN;
    cfg_word[CS_ID_LSB +: 3] = SERIAL_DEVICE_ID;
  end

  always_comb begin
    init_word = '0;
    init_word[ST_INIT_STARTED] = init_started;
    init_word[ST_SELFTEST]     = sw_selftest;
    init_word[ST_INIT_DONE]    = sw_init_done;
    init_word[ST_CHECKSUM_OK]  = sw_checksum_ok;
  end

  always_comb begin
    next_prdata = '0;
    unique case (PADDR)
      REG_STRAP_CAPTURE: next_prdata[STRAP_W-1:0] = strap_cap;
      REG_USER_READBACK: next_prdata[USER_W-1:0]  = user_cap;
      REG_CONFIG_STATUS: next_prdata = cfg_word;
      REG_INIT_STATUS:   next_prdata = init_word;
      default:           next_prdata = '0;
    endcase
  end

  // Address check held from setup through access
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      addr_ok <= 1'b0;
    end else if (apb_setup) begin
      addr_ok <= is_mapped(PADDR);
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      PRDATA  <= '0;
      PSLVERR <= 1'b0;
    end else if (apb_setup) begin
      PRDATA  <= PWRITE ? '0 : next_prdata;
      PSLVERR <= !is_mapped(PADDR);
    end else if (!PSEL) begin
      PSLVERR <= 1'b0;
    end
  end

endmodule // rsc_top
`default_nettype wire

// ==== test/rsc_strap_pulls.sv ====
// Purpose: Board pull resistors on the strap pins
// Assumes: Pulls always present; device drive wins where its enable is high
// Notes:   break_fixed drops the mandatory strap levels for fault runs
`timescale 1ns/10ps
`default_nettype none

module rsc_strap_pulls
  import rsc_pkg::*;
(
  input  wire logic [STRAP_W-1:0] strap_pull,
  input  wire logic [USER_W-1:0]  user_pull,
  input  wire logic               break_fixed,
  input  wire logic [STRAP_W-1:0] dev_out,
  input  wire logic [STRAP_W-1:0] dev_oe,
  output logic      [STRAP_W-1:0] strap_pins,
  output logic      [USER_W-1:0]  user_pins
);
  // ----------------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------------
  logic [STRAP_W-1:0] level;

  // Board keeps reserved and manufacturing straps at their fixed levels
  assign level = break_fixed ? strap_pull
               : (strap_pull & ~STRAP_FIXED_MASK) | STRAP_FIXED_VALUE;
  // Undriven pin settles to its pull
  assign strap_pins = (dev_oe & dev_out) | (~dev_oe & level);
  assign user_pins  = user_pull;
endmodule // rsc_strap_pulls

`default_nettype wire

// ==== test/rsc_top_checker.sv ====
// Purpose: Concurrent checks on the strap capture block ports
// Assumes: Single clock domain, RESET asynchronous active high
// Notes:   Attached to rsc_top by bind at the foot of this file
`timescale 1ns/10ps
`default_nettype none

module rsc_top_checker
  import rsc_pkg::*;
(
  input wire logic               CLK_SYS,
  input wire logic               RESET,
  input wire logic [STRAP_W-1:0] STRAP_TEST_PINS_OUT,
  input wire logic [STRAP_W-1:0] STRAP_TEST_PINS_OE,
  input wire logic               CONFIG_VALID,
  input wire logic               STROBE_DEBOUNCE_EN,
  input wire logic               LIGHTLY_MANAGED,
  input wire logic               HOST_FRAME_BLOCK,
  input wire logic               EEPROM_PRESENT,
  input wire logic               EEPROM_BOOT_EN,
  input wire logic [2:0]         SERIAL_DEVICE_ID,
  input wire logic [USER_W-1:0]  USER_STRAP_READBACK,
  input wire logic               PSEL,
  input wire logic               PENABLE,
  input wire logic               PWRITE,
  input wire logic [ADDR_W-1:0]  PADDR,
  input wire logic [DATA_W-1:0]  PRDATA
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  valid_timing_a: assert property ($fell(RESET) |-> !CONFIG_VALID ##[1:6] CONFIG_VALID)
    else $error("capture not done in time after reset");
  pins_input_a: assert property (!CONFIG_VALID |-> STRAP_TEST_PINS_OE == 16'h0000)
    else $error("strap pins driven before capture");
  oe_release_a: assert property ($rose(CONFIG_VALID) |-> ##[1:4] (STRAP_TEST_PINS_OE == 16'hffff))
    else $error("strap pins not turned to outputs");
  status_pins_a: assert property ((STRAP_TEST_PINS_OE != 16'h0000) |->
    STRAP_TEST_PINS_OUT[0] && STRAP_TEST_PINS_OUT[15:4] == 12'h000)
    else $error("status pin pattern wrong");
  config_hold_a: assert property (CONFIG_VALID && $past(CONFIG_VALID) |->
    $stable({STROBE_DEBOUNCE_EN, HOST_FRAME_BLOCK, EEPROM_PRESENT, SERIAL_DEVICE_ID, USER_STRAP_READBACK}))
    else $error("latched configuration changed");
  mode_split_a: assert property (CONFIG_VALID |-> LIGHTLY_MANAGED != HOST_FRAME_BLOCK)
    else $error("management mode outputs disagree");
  eeprom_boot_a: assert property (CONFIG_VALID |-> EEPROM_BOOT_EN == (HOST_FRAME_BLOCK && EEPROM_PRESENT))
    else $error("eeprom boot enable wrong");
  user_read_a: assert property (PSEL && !PENABLE && !PWRITE && PADDR == REG_USER_READBACK |=>
    PRDATA == {24'h000000, USER_STRAP_READBACK})
    else $error("user strap readback wrong");
  id_read_a: assert property (PSEL && !PENABLE && !PWRITE && PADDR == REG_CONFIG_STATUS |=>
    PRDATA[10:8] == SERIAL_DEVICE_ID && PRDATA[2] == STROBE_DEBOUNCE_EN)
    else $error("config status readback wrong");
endmodule // rsc_top_checker

bind rsc_top rsc_top_checker u_chk (.*);

`default_nettype wire

// ==== test/rsc_top_test.sv ====
// Purpose: Self-checking bench for the strap capture block
// Assumes: APB zero-wait slave, straps latched a few cycles after reset
// Notes:   Each strap pattern gets its own reset; fixed straps broken last
`timescale 1ns/10ps
`default_nettype none

module rsc_top_test
  import rsc_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic        CLK_SYS = 1'b0;
  logic        RESET   = 1'b1;
  logic [15:0] pull_s  = 16'h0000;
  logic [7:0]  pull_u  = 8'h00;
  logic        bad     = 1'b0;
  logic        PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, prdata, rdata;
  logic [15:0] pins_s, s_out, s_oe, cap;
  logic [7:0]  pins_u, user_rb;
  logic [2:0]  dev_id;
  logic        cfg_valid, fault, dbn, lm, hfb, eep, boot, modd, pwr, tmo, pready, pslverr, rerr;
  logic [19:0] snap;
  // Last pattern is unmanaged with the EEPROM fitted, so boot enable goes high
  logic [15:0] pat [4] = '{16'h0000, 16'hffff, 16'h1251, 16'h0a5a};
  logic [7:0]  upat [4] = '{8'h00, 8'hff, 8'ha5, 8'h3c};
  int          n_fail = 0;
  int          total_checks = 0;

  always #5 CLK_SYS = ~CLK_SYS;

  rsc_strap_pulls u_pulls (.strap_pull(pull_s), .user_pull(pull_u), .break_fixed(bad),
    .dev_out(s_out), .dev_oe(s_oe), .strap_pins(pins_s), .user_pins(pins_u));

  rsc_top u_dut (.CLK_SYS(CLK_SYS), .RESET(RESET), .STRAP_TEST_PINS_IN(pins_s),
    .STRAP_TEST_PINS_OUT(s_out), .STRAP_TEST_PINS_OE(s_oe), .PORT_TX_ENABLE_PINS_IN(pins_u),
    .CONFIG_VALID(cfg_valid), .STRAP_FAULT(fault), .STROBE_DEBOUNCE_EN(dbn), .LIGHTLY_MANAGED(lm),
    .HOST_FRAME_BLOCK(hfb), .EEPROM_PRESENT(eep), .EEPROM_BOOT_EN(boot), .SERIAL_DEVICE_ID(dev_id),
    .MODULE_DETECT_EN(modd), .MAC_POWER_SAVE_EN(pwr), .TIMEOUT_RESET_EN(tmo),
    .USER_STRAP_READBACK(user_rb), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic test_done;
    if (n_fail == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Zero-wait slave, but the wait on pready is still bounded
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK_SYS);
    PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= w; PADDR <= a; PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge CLK_SYS);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      n_fail++;
      test_done();
    end
    rdata = prdata;
    rerr  = pslverr;
    PSEL <= 1'b0; PENABLE <= 1'b0;
  endtask

  task automatic boot_with(input logic [15:0] s, input logic [7:0] u, input logic b);
    int n;
    @(posedge CLK_SYS);
    RESET <= 1'b1; pull_s <= s; pull_u <= u; bad <= b;
    repeat (4) @(posedge CLK_SYS);
    RESET <= 1'b0;
    for (n = 0; n < 16; n++) begin
      @(posedge CLK_SYS);
      if (cfg_valid === 1'b1) break;
    end
    if (n == 16) begin
      n_fail++;
      test_done();
    end
    repeat (4) @(posedge CLK_SYS);
    cap = b ? s : (s & ~STRAP_FIXED_MASK) | STRAP_FIXED_VALUE;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 4; i++) begin
      boot_with(pat[i], upat[i], i == 3);
      apb(1'b0, REG_STRAP_CAPTURE, 32'h0);
      chk("strap_capture", rdata, {16'h0000, cap});
      chk("fault", fault, i == 3);
      chk("debounce", dbn, cap[0]);
      chk("mode", {lm, hfb}, {~cap[3], cap[3]});
      chk("eeprom", {eep, boot}, {~cap[7], cap[3] & ~cap[7]});
      chk("device_id", dev_id, cap[6:4]);
      chk("module_detect", modd, cap[9]);
      chk("power_save", pwr, cap[11]);
      chk("timeout_reset", tmo, cap[12]);
      chk("user_pins", user_rb, upat[i]);
      apb(1'b0, REG_USER_READBACK, 32'h0);
      chk("user_reg", rdata, {24'h0, upat[i]});
      apb(1'b0, REG_CONFIG_STATUS, 32'h0);
      chk("config_status", rdata, {21'h0, cap[6:4], cap[12], cap[11], cap[9], ~cap[7], cap[3], cap[0],
        1'(i == 3), 1'b1});
      chk("pin_oe", s_oe, 16'hffff);
      chk("pin_status", {pins_s[15:4], pins_s[0]}, 13'h0001);
      // Pins flipped after capture must not reach the configuration
      snap = {dbn, lm, hfb, eep, boot, dev_id, modd, pwr, tmo, fault, user_rb};
      pull_s <= ~pat[i];
      pull_u <= ~upat[i];
      repeat (8) @(posedge CLK_SYS);
      chk("hold", {dbn, lm, hfb, eep, boot, dev_id, modd, pwr, tmo, fault, user_rb}, snap);
    end
    apb(1'b1, REG_INIT_STATUS, 32'h0000000e);
    apb(1'b0, REG_INIT_STATUS, 32'h0);
    chk("init_status", rdata, 32'h0000000f);
    chk("status_pins", pins_s, 16'h000f);
    apb(1'b1, REG_STRAP_CAPTURE, 32'h0000ffff);
    apb(1'b0, REG_STRAP_CAPTURE, 32'h0);
    chk("capture_ro", rdata, {16'h0000, cap});
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped_err", rerr, 1'b1);
    test_done();
  end
endmodule // rsc_top_test

`default_nettype wire
